// ==== rtl/rlc_codec.sv ====
// Codec table lookups, decoder framing and output pacing with parameter FIFO
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
module rlc_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 16
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int unsigned AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ff;
    logic [AW-1:0] rd_ff;
    logic [AW:0] cnt_ff;
    wire push = in_valid_in && in_ready_out;
    wire pop = out_valid_out && out_ready_in;

    assign in_ready_out = (cnt_ff != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_ff != '0);
    assign out_data_out = mem_ff[rd_ff];

    always_ff @(posedge clk_in)
    begin
        if (push)
            mem_ff[wr_ff] <= in_data_in;
    end

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wr_ff <= '0;
            rd_ff <= '0;
            cnt_ff <= '0;
        end
        else
        begin
            if (push)
                wr_ff <= (wr_ff == AW'(DEPTH - 1)) ? '0 : wr_ff + 1'b1;
            if (pop)
                rd_ff <= (rd_ff == AW'(DEPTH - 1)) ? '0 : rd_ff + 1'b1;
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    a_fifo_push: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (push && !pop) |=> (cnt_ff == $past(cnt_ff) + 1'b1))
        else $error("push not counted");
    a_fifo_pop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pop && !push) |=> (cnt_ff == $past(cnt_ff) - 1'b1))
        else $error("pop not counted");
endmodule

//////////////////////////////////////////////////////////////////////////////
module rlc_codec
    import rlc_pkg::*;
#(
    parameter int unsigned FRAME_WORDS = RLC_FRAME_WORDS,
    parameter int unsigned SAMPLE_CYCLES = RLC_SAMPLE_CYCLES,
    parameter int unsigned FIFO_DEPTH = RLC_FIFO_DEPTH
) (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic state_reset_signal_in,
    input wire logic param_valid_in,
    output logic param_ready_out,
    input wire logic [15:0] param_word_in,
    input wire logic [2:0] lar_index_in,
    input wire logic signed [15:0] gain_metric_in,
    input wire logic [1:0] gain_code_in,
    input wire logic [2:0] mantissa_in,
    input wire logic [3:0] tap_index_in,
    input wire logic signed [15:0] synth_sample_in,
    output rlc_word_s sample_out,
    output logic sample_strobe_out,
    output rlc_ltp_s ltp_out,
    output logic [1:0] gain_code_out,
    output logic signed [15:0] lar_scale_out,
    output logic signed [15:0] lar_offset_out,
    output logic signed [15:0] lar_code_minimum_out,
    output logic signed [15:0] lar_code_maximum_out,
    output logic signed [15:0] reciprocal_scale_out,
    output logic signed [15:0] weight_tap_out,
    output logic signed [15:0] inverse_mantissa_out,
    output logic signed [15:0] direct_mantissa_out,
    output logic frame_done_out
);
    typedef enum logic [1:0] {
        RLC_IDLE = 2'b01,
        RLC_RUN = 2'b10
    } rlc_state_e;

    rlc_state_e state_ff;
    logic [15:0] pace_ff;
    logic [7:0] word_ff;
    logic [7:0] samp_ff;
    logic [6:0] lag_ff;
    logic fifo_valid;
    logic [16:0] fifo_data;
    logic fifo_in_ready;

    //////////////////////////////////////////////////////////////////////////
    // Table lookups are pure constant indexing, so the value is ready in the cycle it is used
    wire [2:0] lar_idx = lar_index_in;
    wire signed [15:0] nxt_scale = RLC_LAR_SCALE[lar_idx];
    wire signed [15:0] nxt_offset = RLC_LAR_OFFSET[lar_idx];
    wire signed [15:0] nxt_min = lar_code_minimum[lar_idx];
    wire signed [15:0] nxt_max = lar_code_maximum[lar_idx];
    wire signed [15:0] nxt_recip = reciprocal_scale_table[lar_idx];
    wire [3:0] tap_idx = (tap_index_in > 4'hA) ? 4'hA : tap_index_in;
    wire signed [15:0] nxt_tap = RLC_WEIGHT_TAPS[tap_idx];
    wire signed [15:0] nxt_inv = inverse_mantissa_table[mantissa_in];
    wire signed [15:0] nxt_dir = direct_mantissa_table[mantissa_in];
    wire signed [15:0] nxt_gain = gain_reconstruction_levels[gain_code_in];

    // Decision: first level the metric does not exceed; 26214 is sensitive, keep exact
    wire [1:0] nxt_gain_code =
        (gain_metric_in <= gain_decision_levels[0]) ? 2'h0 :
        (gain_metric_in <= gain_decision_levels[1]) ? 2'h1 :
        (gain_metric_in <= gain_decision_levels[2]) ? 2'h2 : 2'h3;

    //////////////////////////////////////////////////////////////////////////
    // Parameter framing through the FIFO
    wire word_take = fifo_valid && (state_ff == RLC_RUN);
    // Word sits above the marker bit in the buffered carrier
    wire [6:0] rx_lag = fifo_data[7:1];
    wire lag_ok = (rx_lag >= 7'(RLC_LAG_MIN)) && (rx_lag <= 7'(RLC_LAG_MAX));
    wire is_lag_word = word_take && (word_ff >= 8'h08) && (((word_ff - 8'h08) % 8'h11) == 8'h00);
    wire [6:0] nxt_lag = (is_lag_word && lag_ok) ? rx_lag : lag_ff;
    wire last_word = word_ff == 8'(FRAME_WORDS - 1);
    wire pace_tick = pace_ff == 16'(SAMPLE_CYCLES - 1);
    // Low three bits cleared, so only the 13-bit sample survives
    wire [15:0] nxt_sample = {synth_sample_in[15:3], 3'h0};
    // Taken only while ready shows, so a held word is never stored twice
    wire param_take = param_valid_in && param_ready_out;

    rlc_fifo #(
        .WIDTH(17),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk_in(clk_in),
        .reset_n_in(reset_n_in),
        .in_valid_in(param_take),
        .in_ready_out(fifo_in_ready),
        .in_data_in({param_word_in, 1'b0}),
        .out_valid_out(fifo_valid),
        .out_ready_in(state_ff == RLC_RUN),
        .out_data_out(fifo_data)
    );

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            state_ff <= RLC_IDLE;
            pace_ff <= '0;
            word_ff <= '0;
            samp_ff <= '0;
            lag_ff <= RLC_LAG_RESET;
            param_ready_out <= 1'b0;
            sample_out <= '0;
            sample_strobe_out <= 1'b0;
            ltp_out <= '0;
            gain_code_out <= '0;
            lar_scale_out <= '0;
            lar_offset_out <= '0;
            lar_code_minimum_out <= '0;
            lar_code_maximum_out <= '0;
            reciprocal_scale_out <= '0;
            weight_tap_out <= '0;
            inverse_mantissa_out <= '0;
            direct_mantissa_out <= '0;
            frame_done_out <= 1'b0;
        end
        else if (state_reset_signal_in)
        begin
            // Control state and lag return to initial values; FIFO contents and data outputs are kept
            state_ff <= RLC_IDLE;
            pace_ff <= '0;
            word_ff <= '0;
            samp_ff <= '0;
            lag_ff <= RLC_LAG_RESET;
            param_ready_out <= 1'b0;
            sample_strobe_out <= 1'b0;
            frame_done_out <= 1'b0;
        end
        else
        begin
            state_ff <= RLC_RUN;
            param_ready_out <= fifo_in_ready;
            // Free-running pace keeps output gapless across frames
            pace_ff <= pace_tick ? '0 : pace_ff + 16'h0001;
            sample_strobe_out <= pace_tick && (state_ff == RLC_RUN);
            if (pace_tick)
            begin
                sample_out.word <= nxt_sample;
                sample_out.first <= samp_ff == '0;
                samp_ff <= (samp_ff == 8'(RLC_FRAME_SAMPLES - 1)) ? '0 : samp_ff + 8'h01;
            end
            if (word_take)
                word_ff <= last_word ? '0 : word_ff + 8'h01;
            frame_done_out <= word_take && last_word;
            lag_ff <= nxt_lag;
            ltp_out.lag <= nxt_lag;
            ltp_out.gain_code <= gain_code_in;
            ltp_out.gain <= nxt_gain;
            gain_code_out <= nxt_gain_code;
            lar_scale_out <= nxt_scale;
            lar_offset_out <= nxt_offset;
            lar_code_minimum_out <= nxt_min;
            lar_code_maximum_out <= nxt_max;
            reciprocal_scale_out <= nxt_recip;
            weight_tap_out <= nxt_tap;
            inverse_mantissa_out <= nxt_inv;
            direct_mantissa_out <= nxt_dir;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Counts cycles since the last strobe, so the spacing check needs no long repetition
    logic [15:0] since_strobe_ff;
    logic strobe_seen_ff;

    always_ff @(posedge clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            since_strobe_ff <= '0;
            strobe_seen_ff <= 1'b0;
        end
        else if (state_reset_signal_in)
        begin
            since_strobe_ff <= '0;
            strobe_seen_ff <= 1'b0;
        end
        else if (sample_strobe_out)
        begin
            since_strobe_ff <= '0;
            strobe_seen_ff <= 1'b1;
        end
        else if (since_strobe_ff != 16'hFFFF)
            since_strobe_ff <= since_strobe_ff + 16'h0001;
    end

    a_lag_range: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (lag_ff >= 7'(RLC_LAG_MIN)) && (lag_ff <= 7'(RLC_LAG_MAX)))
        else $error("lag left range");
    a_lag_hold: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (is_lag_word && !lag_ok && !state_reset_signal_in) |=> $stable(lag_ff))
        else $error("bad lag not ignored");
    a_lag_take: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (is_lag_word && lag_ok && !state_reset_signal_in) |=> (lag_ff == $past(rx_lag)))
        else $error("good lag not taken");
    a_state_init: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        state_reset_signal_in |=> (lag_ff == RLC_LAG_RESET && word_ff == '0 &&
        !sample_strobe_out && !frame_done_out))
        else $error("state not returned");
    a_gain_third: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gain_metric_in == 16'sh6666 && !state_reset_signal_in) |=> gain_code_out == 2'h2)
        else $error("third level wrong");
    a_gain_over: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gain_metric_in == 16'sh6667 && !state_reset_signal_in) |=> gain_code_out == 2'h3)
        else $error("third level off");
    a_gain_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gain_metric_in == 16'sh199A && !state_reset_signal_in) |=> gain_code_out == 2'h0)
        else $error("first level wrong");
    a_gain_rebuild: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gain_code_in == 2'h1 && !state_reset_signal_in) |=> ltp_out.gain == 16'sh2CCD)
        else $error("gain rebuild wrong");
    a_gain_top: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (gain_code_in == 2'h3 && !state_reset_signal_in) |=> ltp_out.gain == 16'sh7FFF)
        else $error("top gain rebuild wrong");
    a_out_pad: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sample_out.word[2:0] == 3'h0)
        else $error("low bits not zero");
    a_sample_word: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pace_tick && !state_reset_signal_in) |=>
        (sample_out.word == {$past(synth_sample_in[15:3]), 3'h0}))
        else $error("sample word wrong");
    a_first_mark: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (pace_tick && samp_ff == '0 && !state_reset_signal_in) |=> sample_out.first)
        else $error("frame start not marked");
    a_mant_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (mantissa_in == 3'h7 && !state_reset_signal_in) |=>
        (inverse_mantissa_out == 16'sh4000 && direct_mantissa_out == 16'sh7FFF))
        else $error("mantissa lookup wrong");
    a_mant_low: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (mantissa_in == 3'h0 && !state_reset_signal_in) |=>
        (inverse_mantissa_out == 16'sh71C8 && direct_mantissa_out == 16'sh47FF))
        else $error("low mantissa lookup wrong");
    a_recip_pair: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (lar_index_in == 3'h4 && !state_reset_signal_in) |=>
        (reciprocal_scale_out == 16'sh4B17 && lar_scale_out == 16'sh368C))
        else $error("lar lookup wrong");
    a_lar_seventh: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (lar_index_in == 3'h6 && !state_reset_signal_in) |=>
        (reciprocal_scale_out == 16'sh7ADE && lar_scale_out == 16'sh2156))
        else $error("seventh lar lookup wrong");
    a_code_limits: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (lar_index_in == 3'h0 && !state_reset_signal_in) |=>
        (lar_code_minimum_out == -16'sh0020 && lar_code_maximum_out == 16'sh001F))
        else $error("code limits wrong");
    a_tap_center: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (tap_index_in == 4'h5 && !state_reset_signal_in) |=> weight_tap_out == 16'sh2000)
        else $error("center tap wrong");
    a_tap_clamp: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (tap_index_in > 4'hA && !state_reset_signal_in) |=> weight_tap_out == -16'sh0086)
        else $error("clamped tap wrong");
    a_frame_end: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        (word_take && last_word && !state_reset_signal_in) |=> frame_done_out)
        else $error("frame end not flagged");
    a_strobe_gap: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        sample_strobe_out |=> !sample_strobe_out)
        else $error("strobe too long");
    a_strobe_period: assert property (@(posedge clk_in) disable iff (!reset_n_in)
        strobe_seen_ff |-> (sample_strobe_out == (since_strobe_ff == 16'(SAMPLE_CYCLES - 1))))
        else $error("strobe spacing wrong");
endmodule

// ==== pkg/rlc_pkg.sv ====
// Package with constant tables, framing constants and carrier types for the codec block
package rlc_pkg;

    localparam int unsigned RLC_CLK_HZ = 100_000_000;
    localparam int unsigned RLC_SAMPLE_HZ = 8_000;
    localparam int unsigned RLC_SAMPLE_CYCLES = RLC_CLK_HZ / RLC_SAMPLE_HZ;
    localparam int unsigned RLC_FRAME_MS = 20;
    localparam int unsigned RLC_FRAME_SAMPLES = RLC_SAMPLE_HZ * RLC_FRAME_MS / 1000;
    localparam int unsigned RLC_FRAME_WORDS = 76;
    localparam int unsigned RLC_WORD_W = 16;
    localparam int unsigned RLC_OUT_PAD = 3;
    localparam int unsigned RLC_LAG_MIN = 40;
    localparam int unsigned RLC_LAG_MAX = 120;
    localparam logic [6:0] RLC_LAG_RESET = 7'h28;
    localparam int unsigned RLC_FIFO_DEPTH = 16;
    localparam int unsigned RLC_XMAX_CODES = 64;

    // Log-area quantizer rows, coefficient one to eight
    localparam logic signed [15:0] RLC_LAR_SCALE [8] = '{
        16'sh5000, 16'sh5000, 16'sh5000, 16'sh5000,
        16'sh368C, 16'sh3C00, 16'sh2156, 16'sh234C};
    localparam logic signed [15:0] RLC_LAR_OFFSET [8] = '{
        16'sh0000, 16'sh0000, 16'sh0800, -16'sh0A00,
        16'sh005E, -16'sh0700, -16'sh0155, -16'sh0478};
    localparam logic signed [15:0] lar_code_minimum [8] = '{
        -16'sh0020, -16'sh0020, -16'sh0010, -16'sh0010,
        -16'sh0008, -16'sh0008, -16'sh0004, -16'sh0004};
    localparam logic signed [15:0] lar_code_maximum [8] = '{
        16'sh001F, 16'sh001F, 16'sh000F, 16'sh000F,
        16'sh0007, 16'sh0007, 16'sh0003, 16'sh0003};
    localparam logic signed [15:0] reciprocal_scale_table [8] = '{
        16'sh3333, 16'sh3333, 16'sh3333, 16'sh3333,
        16'sh4B17, 16'sh4444, 16'sh7ADE, 16'sh740C};
    localparam logic signed [15:0] gain_decision_levels [4] = '{
        16'sh199A, 16'sh4000, 16'sh6666, 16'sh7FFF};
    localparam logic signed [15:0] gain_reconstruction_levels [4] = '{
        16'sh0CCD, 16'sh2CCD, 16'sh5333, 16'sh7FFF};
    localparam logic signed [15:0] RLC_WEIGHT_TAPS [11] = '{
        -16'sh0086, -16'sh0176, 16'sh0000, 16'sh0806, 16'sh166D, 16'sh2000,
        16'sh166D, 16'sh0806, 16'sh0000, -16'sh0176, -16'sh0086};
    localparam logic signed [15:0] inverse_mantissa_table [8] = '{
        16'sh71C8, 16'sh6667, 16'sh5D18, 16'sh5556,
        16'sh4EC5, 16'sh4925, 16'sh4444, 16'sh4000};
    localparam logic signed [15:0] direct_mantissa_table [8] = '{
        16'sh47FF, 16'sh4FFF, 16'sh57FF, 16'sh5FFF,
        16'sh67FF, 16'sh6FFF, 16'sh77FF, 16'sh7FFF};

    typedef struct packed {
        logic [15:0] word;
        logic first;
    } rlc_word_s;

    typedef struct packed {
        logic signed [15:0] gain;
        logic [6:0] lag;
        logic [1:0] gain_code;
    } rlc_ltp_s;

endpackage

// ==== verif/rlc_param_source.sv ====
// Behavioural source of coded parameter frames for the codec block
`timescale 1ns/10ps
module rlc_param_source (
    input wire logic clk_in,
    input wire logic param_ready_in,
    output logic param_valid_out,
    output logic [15:0] param_word_out
);
    initial
    begin
        param_valid_out = 1'b0;
        param_word_out = 16'h0000;
    end

    //////////////////////////////////////////////////////////////////////////////
    // One frame; lag codes sit at their fixed slots, gap idles between words
    task automatic send_frame(input logic [6:0] l0, l1, l2, l3, input int gap);
        int w;
        for (int n = 0; n < 76; n++)
        begin
            param_word_out = (n == 8) ? {9'h000, l0} : (n == 25) ? {9'h000, l1} :
                (n == 42) ? {9'h000, l2} : (n == 59) ? {9'h000, l3} : {13'h0000, 3'(n)};
            param_valid_out = 1'b1;
            w = 0;
            do
            begin
                @(posedge clk_in);
                w++;
            end
            while (param_ready_in !== 1'b1 && w < 200);
            #1;
            if (gap > 0)
            begin
                // Released bus shows the inverse so a stale word is never taken as fresh
                param_valid_out = 1'b0;
                param_word_out = ~param_word_out;
                repeat (gap) @(posedge clk_in);
                #1;
            end
        end
        param_valid_out = 1'b0;
        param_word_out = ~param_word_out;
    endtask
endmodule

// ==== verif/test_rpe_ltp_codec_tables_and_framing.sv ====
// Self-checking testbench for the codec tables, framing and output pacing
`timescale 1ns/10ps
module test_rpe_ltp_codec_tables_and_framing
    import rlc_pkg::*;
;
    logic clk_in, reset_n_in, state_reset, param_valid, param_ready, sample_strobe, frame_done;
    logic [15:0] param_word;
    logic [2:0] lar_index, mantissa;
    logic [1:0] gain_code, gain_dec;
    logic [3:0] tap_index;
    logic signed [15:0] gain_metric, synth, scale, offset, cmin, cmax, recip, tap, inv_m, dir_m;
    rlc_word_s sample;
    rlc_ltp_s ltp;
    int errors, check_count;
    int done_count = 0;
    localparam logic [15:0] exp_scale [8] = '{16'h5000, 16'h5000, 16'h5000, 16'h5000,
        16'h368C, 16'h3C00, 16'h2156, 16'h234C};
    localparam logic [15:0] exp_offset [8] = '{16'h0000, 16'h0000, 16'h0800, 16'hF600,
        16'h005E, 16'hF900, 16'hFEAB, 16'hFB88};
    localparam logic [15:0] exp_min [8] = '{16'hFFE0, 16'hFFE0, 16'hFFF0, 16'hFFF0,
        16'hFFF8, 16'hFFF8, 16'hFFFC, 16'hFFFC};
    localparam logic [15:0] exp_max [8] = '{16'h001F, 16'h001F, 16'h000F, 16'h000F,
        16'h0007, 16'h0007, 16'h0003, 16'h0003};
    localparam logic [15:0] exp_recip [8] = '{16'h3333, 16'h3333, 16'h3333, 16'h3333,
        16'h4B17, 16'h4444, 16'h7ADE, 16'h740C};
    localparam logic [15:0] exp_inv [8] = '{16'h71C8, 16'h6667, 16'h5D18, 16'h5556,
        16'h4EC5, 16'h4925, 16'h4444, 16'h4000};
    localparam logic [15:0] exp_dir [8] = '{16'h47FF, 16'h4FFF, 16'h57FF, 16'h5FFF,
        16'h67FF, 16'h6FFF, 16'h77FF, 16'h7FFF};
    localparam logic [15:0] exp_recon [4] = '{16'h0CCD, 16'h2CCD, 16'h5333, 16'h7FFF};
    localparam logic [15:0] exp_tap [11] = '{16'hFF7A, 16'hFE8A, 16'h0000, 16'h0806,
        16'h166D, 16'h2000, 16'h166D, 16'h0806, 16'h0000, 16'hFE8A, 16'hFF7A};
    // Metrics straddle each decision level by one, the third level most of all
    localparam logic [15:0] metric [8] = '{16'hFFFB, 16'h199A, 16'h199B, 16'h4000,
        16'h4001, 16'h6666, 16'h6667, 16'h7FFF};
    localparam logic [1:0] exp_code [8] = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};

    //////////////////////////////////////////////////////////////////////////////
    // Short sample period keeps the pacing run brief
    rlc_codec #(.SAMPLE_CYCLES(32'h14)) i_dut (.clk_in(clk_in), .reset_n_in(reset_n_in),
        .state_reset_signal_in(state_reset), .param_valid_in(param_valid),
        .param_ready_out(param_ready), .param_word_in(param_word), .lar_index_in(lar_index),
        .gain_metric_in(gain_metric), .gain_code_in(gain_code), .mantissa_in(mantissa),
        .tap_index_in(tap_index), .synth_sample_in(synth), .sample_out(sample),
        .sample_strobe_out(sample_strobe), .ltp_out(ltp), .gain_code_out(gain_dec),
        .lar_scale_out(scale), .lar_offset_out(offset), .lar_code_minimum_out(cmin),
        .lar_code_maximum_out(cmax), .reciprocal_scale_out(recip), .weight_tap_out(tap),
        .inverse_mantissa_out(inv_m), .direct_mantissa_out(dir_m), .frame_done_out(frame_done));
    rlc_param_source i_src (.clk_in(clk_in), .param_ready_in(param_ready),
        .param_valid_out(param_valid), .param_word_out(param_word));

    initial
    begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // Counted mid-cycle, where the one-cycle pulse has settled
    always @(negedge clk_in)
        if (frame_done === 1'b1)
            done_count++;

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            errors++;
            $display("BAD %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        $display("Checks %0d, errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    //////////////////////////////////////////////////////////////////////////////
    task automatic test_tables();
        for (int i = 0; i < 13; i++)
        begin
            lar_index = 3'(i);
            mantissa = 3'(i);
            gain_code = 2'(i);
            tap_index = 4'(i);
            @(posedge clk_in);
            #1;
            check("tap", tap, exp_tap[i > 10 ? 10 : i]);
            if (i < 8)
            begin
                check("scale", scale, exp_scale[i]);
                check("offset", offset, exp_offset[i]);
                check("code_min", cmin, exp_min[i]);
                check("code_max", cmax, exp_max[i]);
                check("recip", recip, exp_recip[i]);
                check("inv_mant", inv_m, exp_inv[i]);
                check("dir_mant", dir_m, exp_dir[i]);
                check("gain", ltp.gain, exp_recon[i % 4]);
                check("gain_echo", {14'h0000, ltp.gain_code}, {14'h0000, 2'(i)});
            end
        end
    endtask

    task automatic test_gain_decision();
        for (int i = 0; i < 8; i++)
        begin
            gain_metric = metric[i];
            @(posedge clk_in);
            #1;
            check("gain_code", {14'h0000, gain_dec}, {14'h0000, exp_code[i]});
        end
    endtask

    task automatic test_frame(input logic [6:0] l0, l1, l2, l3, input int gap,
        input logic [6:0] lag);
        int start;
        int w;
        start = done_count;
        i_src.send_frame(l0, l1, l2, l3, gap);
        w = 0;
        while (done_count == start && w < 60)
        begin
            @(posedge clk_in);
            #1;
            w++;
        end
        repeat (4) @(posedge clk_in);
        #1;
        check("frames", 16'(done_count - start), 16'h0001);
        check("lag", {9'h000, ltp.lag}, {9'h000, lag});
    endtask

    task automatic test_pacing();
        int gap;
        int since;
        since = -1;
        for (int k = 0; k < 340; k++)
        begin
            gap = 0;
            do
            begin
                @(posedge clk_in);
                #1;
                gap++;
            end
            while (sample_strobe !== 1'b1 && gap < 100);
            if (k > 0)
            begin
                check("pace", 16'(gap), 16'h0014);
                check("sample", sample.word, 16'hA5A0);
            end
            if (sample.first === 1'b1)
            begin
                if (since >= 0)
                    check("frame_len", 16'(since), 16'h00A0);
                since = 1;
            end
            else if (since >= 0)
                since++;
        end
    endtask

    //////////////////////////////////////////////////////////////////////////////
    initial
    begin
        errors = 0;
        check_count = 0;
        reset_n_in = 1'b0;
        state_reset = 1'b0;
        lar_index = 3'h0;
        mantissa = 3'h0;
        gain_code = 2'h0;
        tap_index = 4'h0;
        gain_metric = 16'h0000;
        synth = 16'hA5A7;
        repeat (3) @(posedge clk_in);
        #1;
        reset_n_in = 1'b1;
        test_tables();
        test_gain_decision();
        test_frame(7'h79, 7'h4D, 7'h27, 7'h7F, 2, 7'h4D);
        state_reset = 1'b1;
        @(posedge clk_in);
        #1;
        state_reset = 1'b0;
        test_frame(7'h00, 7'h7F, 7'h27, 7'h79, 0, 7'h28);
        test_frame(7'h78, 7'h03, 7'h28, 7'h7D, 0, 7'h28);
        test_pacing();
        complete_run();
    end

    // Whole run needs under ten thousand cycles
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        complete_run();
    end
endmodule
